/* logic/flash_spi_target.sv */
// Serial flash target logic: bus decode, status, protection and the
// engine that hands program and erase work to the memory array.
// Assumes the array performs each request and pulses ARRAY_DONE once
// after the request marked last; program requests only clear bits.
module flash_spi_target #(
  // Instruction codes; the default values are arbitrary.
  parameter logic [7:0] OP_WRITE_ENABLE  = 8'h01,
  parameter logic [7:0] OP_WRITE_DISABLE = 8'h02,
  parameter logic [7:0] OP_READ_STATUS   = 8'h03,
  parameter logic [7:0] OP_WRITE_STATUS  = 8'h04,
  parameter logic [7:0] OP_PAGE_PROGRAM  = 8'h05,
  parameter logic [7:0] OP_SECTOR_ERASE  = 8'h06,
  parameter logic [7:0] OP_BULK_ERASE    = 8'h07
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        SPI_CLK,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_MOSI,
  input  wire logic        HOLD_N,
  input  wire logic        WP_N,
  input  wire logic        BOOST_VOLTAGE_LEVEL,
  output      logic        SPI_MISO,
  output      logic        SPI_MISO_OE,
  output      logic        STANDBY,
  output      logic        WRITE_IN_PROGRESS_FLAG,
  output      logic        WRITE_ENABLE_LATCH,
  output      logic [2:0]  BLOCK_PROTECT,
  output      logic        ARRAY_REQ_VALID,
  input  wire logic        ARRAY_REQ_READY,
  output      logic [1:0]  ARRAY_REQ_OP,
  output      logic [23:0] ARRAY_REQ_ADDR,
  output      logic [7:0]  ARRAY_REQ_DATA,
  output      logic        ARRAY_REQ_FAST,
  output      logic        ARRAY_REQ_LAST,
  input  wire logic        ARRAY_DONE
);

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DATA, ST_STATUS_OUT, ST_STATUS_IN,
    ST_DONE, ST_IGNORE
  } bus_state_t;

  typedef enum logic [1:0] {
    EN_IDLE, EN_PROG, EN_ERASE, EN_WAIT
  } engine_state_t;

  typedef struct packed {
    logic [2:0]                 cs_sync;
    logic [2:0]                 clk_sync;
    logic [1:0]                 mosi_sync;
    logic [1:0]                 hold_sync;
    logic [1:0]                 wp_sync;
    logic [1:0]                 boost_sync;
    logic                       armed;
    logic                       hold;
    bus_state_t                 bus;
    logic [2:0]                 bitc;
    logic [7:0]                 rx;
    logic [7:0]                 tx;
    logic [7:0]                 opcode;
    logic [1:0]                 addr_cnt;
    logic [23:0]                addr;
    logic [8:0]                 count;
    logic [7:0]                 start;
    logic [255:0][7:0]          page;
    logic [7:0]                 new_status;
    logic                       wlatch;
    logic                       busy;
    logic [2:0]                 bp;
    engine_state_t              en;
    logic                       bulk;
    logic                       fast;
    logic [8:0]                 emit;
    logic [7:0]                 emit_off;
    logic                       miso;
    logic                       miso_oe;
    logic                       standby;
  } target_state_t;

  target_state_t s_reg;
  target_state_t s_next;

  logic                              cs_high;
  logic                              cs_rise;
  logic                              cs_fall;
  logic                              clk_rise;
  logic                              clk_fall;
  logic                              wp_freeze;
  logic                              push_valid;
  logic                              push_ready;
  logic [flash_spi_pkg::REQ_W-1:0]   push_data;
  logic [flash_spi_pkg::REQ_W-1:0]   req_word;

  // A locked sector lies in the upper part sized by the protect bits.
  function automatic logic sector_locked(input logic [2:0] bp,
                                         input logic [5:0] sector);
    logic [6:0] span;
    span = 7'h00;
    if (bp == flash_spi_pkg::BP_ALL) begin
      span = flash_spi_pkg::SECTOR_COUNT;
    end else if (bp != 3'h0) begin
      span = 7'h01 << (bp - 3'h1);
    end
    return (span != 7'h00) &&
           ({1'b0, sector} >= (flash_spi_pkg::SECTOR_COUNT - span));
  endfunction

  // Edges come from the second and third stages only, so either idle
  // clock level gives the same capture and shift points.
  assign cs_high  = s_reg.cs_sync[1];
  assign cs_rise  = s_reg.cs_sync[1] & ~s_reg.cs_sync[2];
  assign cs_fall  = ~s_reg.cs_sync[1] & s_reg.cs_sync[2];
  assign clk_rise = s_reg.clk_sync[1] & ~s_reg.clk_sync[2];
  assign clk_fall = ~s_reg.clk_sync[1] & s_reg.clk_sync[2];
  // At boost level the pin is a supply and no longer a control input.
  assign wp_freeze = ~s_reg.wp_sync[1] & ~s_reg.boost_sync[1];

  always_comb begin
    logic [7:0] rx_n;
    logic [7:0] status;
    logic       active;
    logic       whole;
    rx_n   = {s_reg.rx[6:0], s_reg.mosi_sync[1]};
    active = 1'b0;
    whole  = 1'b0;
    status = 8'h00;
    status[flash_spi_pkg::STAT_BUSY_BIT]  = s_reg.busy;
    status[flash_spi_pkg::STAT_LATCH_BIT] = s_reg.wlatch;
    status[flash_spi_pkg::STAT_BP_LSB +: flash_spi_pkg::BP_W] = s_reg.bp;
    s_next = s_reg;
    s_next.cs_sync    = {s_reg.cs_sync[1:0], SPI_CS_N};
    s_next.clk_sync   = {s_reg.clk_sync[1:0], SPI_CLK};
    s_next.mosi_sync  = {s_reg.mosi_sync[0], SPI_MOSI};
    s_next.hold_sync  = {s_reg.hold_sync[0], HOLD_N};
    s_next.wp_sync    = {s_reg.wp_sync[0], WP_N};
    s_next.boost_sync = {s_reg.boost_sync[0], BOOST_VOLTAGE_LEVEL};

    if (cs_fall) begin
      s_next.armed = 1'b1;
    end
    // Hold follows its pin only while the serial clock is low; deselect clears it at any clock level.
    if (cs_high) begin
      s_next.hold = 1'b0;
    end else if (!s_reg.clk_sync[1]) begin
      s_next.hold = ~s_reg.hold_sync[1];
    end
    active = ~cs_high & ~s_reg.hold & s_reg.armed;

    if (cs_high) begin
      s_next.bus      = ST_OPCODE;
      s_next.bitc     = 3'h0;
      s_next.addr_cnt = 2'h0;
    end else if (active && clk_rise) begin
      s_next.rx   = rx_n;
      s_next.bitc = s_reg.bitc + 3'h1;
      if (s_reg.bitc == 3'h7) begin
        unique case (s_reg.bus)
          ST_OPCODE: begin
            s_next.opcode = rx_n;
            s_next.bus    = ST_IGNORE;
            if (rx_n == OP_READ_STATUS) begin
              s_next.bus = ST_STATUS_OUT;
              s_next.tx  = status;
            end else if (s_reg.busy) begin
              s_next.bus = ST_IGNORE;
            end else if (rx_n == OP_WRITE_ENABLE ||
                         rx_n == OP_WRITE_DISABLE ||
                         rx_n == OP_BULK_ERASE) begin
              s_next.bus = ST_DONE;
            end else if (rx_n == OP_WRITE_STATUS) begin
              s_next.bus = ST_STATUS_IN;
            end else if (rx_n == OP_PAGE_PROGRAM ||
                         rx_n == OP_SECTOR_ERASE) begin
              s_next.bus   = ST_ADDR;
              s_next.count = 9'h000;
            end
          end
          ST_ADDR: begin
            s_next.addr     = {s_reg.addr[15:0], rx_n};
            s_next.addr_cnt = s_reg.addr_cnt + 2'h1;
            if (s_reg.addr_cnt == 2'h2) begin
              s_next.start = rx_n;
              s_next.bus   = (s_reg.opcode == OP_PAGE_PROGRAM) ?
                             ST_DATA : ST_DONE;
            end
          end
          ST_DATA: begin
            // Past a full page the oldest byte is overwritten in turn.
            if (s_reg.count == flash_spi_pkg::PAGE_FULL) begin
              s_next.page[s_reg.start] = rx_n;
              s_next.start = s_reg.start + 8'h01;
            end else begin
              s_next.page[s_reg.start + s_reg.count[7:0]] = rx_n;
              s_next.count = s_reg.count + 9'h001;
            end
          end
          ST_STATUS_IN: begin
            s_next.new_status = rx_n;
            s_next.bus        = ST_DONE;
          end
          ST_STATUS_OUT: begin
            s_next.tx = status;
          end
          ST_DONE: begin
            s_next.bus = ST_IGNORE;
          end
          ST_IGNORE: begin
          end
          default: begin
            s_next.bus = ST_IGNORE;
          end
        endcase
      end
    end else if (active && clk_fall && s_reg.bus == ST_STATUS_OUT) begin
      s_next.miso = s_reg.tx[7];
      s_next.tx   = {s_reg.tx[6:0], 1'b0};
    end

    // Commands act on deselect, and only after whole bytes.
    whole = (s_reg.bitc == 3'h0);
    if (cs_rise && s_reg.armed && whole && !s_reg.busy) begin
      if (s_reg.opcode == OP_WRITE_ENABLE && s_reg.bus == ST_DONE) begin
        s_next.wlatch = 1'b1;
      end else if (s_reg.opcode == OP_WRITE_DISABLE &&
                   s_reg.bus == ST_DONE) begin
        s_next.wlatch = 1'b0;
      end else if (s_reg.opcode == OP_WRITE_STATUS &&
                   s_reg.bus == ST_DONE) begin
        if (s_reg.wlatch && !wp_freeze) begin
          s_next.bp = s_reg.new_status[flash_spi_pkg::STAT_BP_LSB +:
                                       flash_spi_pkg::BP_W];
        end
        s_next.wlatch = 1'b0;
      end else if (s_reg.opcode == OP_PAGE_PROGRAM &&
                   s_reg.bus == ST_DATA && s_reg.count != 9'h000) begin
        if (s_reg.wlatch && !sector_locked(s_reg.bp,
            s_reg.addr[flash_spi_pkg::SECTOR_LSB +:
                       flash_spi_pkg::SECTOR_W])) begin
          s_next.en       = EN_PROG;
          s_next.emit     = s_reg.count;
          s_next.emit_off = s_reg.start;
          s_next.busy     = 1'b1;
          s_next.fast     = s_reg.boost_sync[1];
        end
        s_next.wlatch = 1'b0;
      end else if ((s_reg.opcode == OP_SECTOR_ERASE ||
                    s_reg.opcode == OP_BULK_ERASE) &&
                   s_reg.bus == ST_DONE) begin
        if (s_reg.wlatch &&
            ((s_reg.opcode == OP_SECTOR_ERASE &&
              !sector_locked(s_reg.bp,
                s_reg.addr[flash_spi_pkg::SECTOR_LSB +:
                           flash_spi_pkg::SECTOR_W])) ||
             (s_reg.opcode == OP_BULK_ERASE && s_reg.bp == 3'h0))) begin
          s_next.en   = EN_ERASE;
          s_next.bulk = (s_reg.opcode == OP_BULK_ERASE);
          s_next.busy = 1'b1;
          s_next.fast = s_reg.boost_sync[1];
        end
        s_next.wlatch = 1'b0;
      end
    end

    // Engine: feeds the request buffer and waits for the array.
    push_valid = 1'b0;
    push_data  = '0;
    push_data[flash_spi_pkg::REQ_FAST_BIT] = s_reg.fast;
    unique case (s_reg.en)
      EN_IDLE: begin
      end
      EN_PROG: begin
        push_valid = 1'b1;
        push_data[flash_spi_pkg::REQ_OP_LSB +: 2] =
          flash_spi_pkg::ARR_PROGRAM;
        push_data[flash_spi_pkg::REQ_ADDR_LSB +: flash_spi_pkg::ADDR_W] =
          {s_reg.addr[23:flash_spi_pkg::PAGE_LSB], s_reg.emit_off};
        push_data[flash_spi_pkg::REQ_DATA_LSB +: flash_spi_pkg::BYTE_W] =
          s_reg.page[s_reg.emit_off];
        push_data[flash_spi_pkg::REQ_LAST_BIT] = (s_reg.emit == 9'h001);
        if (push_ready) begin
          s_next.emit     = s_reg.emit - 9'h001;
          s_next.emit_off = s_reg.emit_off + 8'h01;
          if (s_reg.emit == 9'h001) begin
            s_next.en = EN_WAIT;
          end
        end
      end
      EN_ERASE: begin
        push_valid = 1'b1;
        push_data[flash_spi_pkg::REQ_OP_LSB +: 2] =
          s_reg.bulk ? flash_spi_pkg::ARR_ERASE_BULK :
                       flash_spi_pkg::ARR_ERASE_SECTOR;
        push_data[flash_spi_pkg::REQ_ADDR_LSB +: flash_spi_pkg::ADDR_W] =
          s_reg.addr;
        push_data[flash_spi_pkg::REQ_DATA_LSB +: flash_spi_pkg::BYTE_W] =
          flash_spi_pkg::ERASED_BYTE;
        push_data[flash_spi_pkg::REQ_LAST_BIT] = 1'b1;
        if (push_ready) begin
          s_next.en = EN_WAIT;
        end
      end
      EN_WAIT: begin
        if (ARRAY_DONE) begin
          s_next.en  = EN_IDLE;
          s_next.busy = 1'b0;
        end
      end
    endcase

    s_next.standby = cs_high & ~s_reg.busy;
    s_next.miso_oe = ~cs_high & ~s_next.hold &
                     (s_next.bus == ST_STATUS_OUT);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      // Hold and protect stages start at their pins' idle level, so no
      // false hold or freeze appears in the cycles after reset.
      s_reg           <= '0;
      s_reg.hold_sync <= 2'h3;
      s_reg.wp_sync   <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  flash_req_buffer #(
    .WIDTH (flash_spi_pkg::REQ_W),
    .DEPTH (flash_spi_pkg::BUF_DEPTH)
  ) u_req_buffer (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (ARRAY_REQ_VALID),
    .out_ready (ARRAY_REQ_READY),
    .out_data  (req_word)
  );

  assign ARRAY_REQ_OP   = req_word[flash_spi_pkg::REQ_OP_LSB +: 2];
  assign ARRAY_REQ_ADDR = req_word[flash_spi_pkg::REQ_ADDR_LSB +: 24];
  assign ARRAY_REQ_DATA = req_word[flash_spi_pkg::REQ_DATA_LSB +: 8];
  assign ARRAY_REQ_FAST = req_word[flash_spi_pkg::REQ_FAST_BIT];
  assign ARRAY_REQ_LAST = req_word[flash_spi_pkg::REQ_LAST_BIT];

  assign SPI_MISO               = s_reg.miso;
  assign SPI_MISO_OE            = s_reg.miso_oe;
  assign STANDBY                = s_reg.standby;
  assign WRITE_IN_PROGRESS_FLAG = s_reg.busy;
  assign WRITE_ENABLE_LATCH     = s_reg.wlatch;
  assign BLOCK_PROTECT          = s_reg.bp;

  sequence s_engine_start;
    (s_reg.en == EN_IDLE) ##1 (s_reg.en != EN_IDLE);
  endsequence

  AST_MISO_AFTER_FALL: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) $changed(s_reg.miso) |-> $past(clk_fall))
    else $error("output bit changed without a falling clock edge");
  AST_SHIFT_ON_RISE: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST)
    $changed(s_reg.bitc) |-> ($past(clk_rise) || $past(cs_high)))
    else $error("bit count moved without a rising clock edge");
  AST_FLOAT_DESELECTED: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) cs_high |=> !SPI_MISO_OE)
    else $error("output driven while deselected");
  AST_STANDBY_IDLE: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) STANDBY == $past(cs_high && !s_reg.busy))
    else $error("standby does not follow select and busy");
  AST_UNARMED_QUIET: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST)
    !s_reg.armed |-> (s_reg.bitc == 3'h0 && !s_reg.wlatch))
    else $error("activity before the first select edge");
  AST_HOLD_FLOATS: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) s_reg.hold |-> !SPI_MISO_OE)
    else $error("output driven during hold");
  AST_HOLD_SELECTED: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) $rose(s_reg.hold) |-> !$past(cs_high))
    else $error("hold entered while deselected");
  AST_BP_FROZEN: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) $changed(s_reg.bp) |-> !$past(wp_freeze))
    else $error("protect bits changed while frozen");
  AST_FAST_LATCHED: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST)
    s_engine_start |-> s_reg.fast == $past(s_reg.boost_sync[1]))
    else $error("fast mode not taken from boost level");
  AST_START_NEEDS_LATCH: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) s_engine_start |-> $past(s_reg.wlatch))
    else $error("cycle started without write enable");
  AST_START_WHOLE_BYTES: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST) s_engine_start |-> $past(s_reg.bitc) == 3'h0)
    else $error("cycle started after a partial byte");
  AST_START_FLAGS: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST)
    s_engine_start |-> (s_reg.busy && !s_reg.wlatch))
    else $error("busy or latch wrong at cycle start");
  AST_BULK_UNPROTECTED: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST)
    (s_reg.en == EN_ERASE && s_reg.bulk) |-> s_reg.bp == 3'h0)
    else $error("bulk erase with protected blocks");

endmodule

/* logic/flash_spi_pkg.sv */
// Shared constants for the serial flash target: array geometry, status
// byte layout and the request word handed to the memory array.
// Assumes a single system clock; the serial bus pins are asynchronous.
package flash_spi_pkg;

  // Array geometry: 64 sectors of 1024 pages of 256 bytes.
  localparam int          ADDR_W           = 24;
  localparam int          BYTE_W           = 8;
  localparam int          PAGE_BYTES       = 256;
  localparam int          PAGES_PER_SECTOR = 1024;
  localparam int          SECTOR_LSB       = 18;
  localparam int          SECTOR_W         = 6;
  localparam int          PAGE_LSB         = 8;
  localparam logic [6:0]  SECTOR_COUNT     = 7'h40;
  localparam logic [8:0]  PAGE_FULL        = 9'h100;
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;

  // Status byte layout.
  localparam int          STAT_BUSY_BIT    = 0;
  localparam int          STAT_LATCH_BIT   = 1;
  localparam int          STAT_BP_LSB      = 2;
  localparam int          BP_W             = 3;
  localparam logic [2:0]  BP_ALL           = 3'h7;

  // Request word towards the array.
  localparam int          REQ_LAST_BIT     = 0;
  localparam int          REQ_FAST_BIT     = 1;
  localparam int          REQ_DATA_LSB     = 2;
  localparam int          REQ_ADDR_LSB     = 10;
  localparam int          REQ_OP_LSB       = 34;
  localparam int          REQ_W            = 36;
  localparam int          BUF_DEPTH        = 2;

  typedef enum logic [1:0] {
    ARR_PROGRAM,
    ARR_ERASE_SECTOR,
    ARR_ERASE_BULK
  } array_op_t;

endpackage

/* logic/flash_req_buffer.sv */
// Small shift-register FIFO with valid and ready on both sides.
// Assumes both sides run on SYS_CLK; the head entry is a flip-flop.
module flash_req_buffer #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0]            vld;
  } buf_state_t;

  buf_state_t s_reg;
  buf_state_t s_next;

  // Full is taken before a pop, so a stalled drain really back-pressures.
  assign in_ready  = ~s_reg.vld[DEPTH-1];
  assign out_valid = s_reg.vld[0];
  assign out_data  = s_reg.mem[0];

  always_comb begin
    logic placed;
    placed = 1'b0;
    s_next = s_reg;
    if (s_reg.vld[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_next.mem[i] = s_reg.mem[i+1];
        s_next.vld[i] = s_reg.vld[i+1];
      end
      s_next.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && in_ready) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !s_next.vld[i]) begin
          s_next.mem[i] = in_data;
          s_next.vld[i] = 1'b1;
          placed        = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* verification/spi_master_model.sv */
// Bus master model for the serial flash target: frames, bits and hold.
// The start task itself waits for a falling system clock edge before each frame.
module spi_master_model (
  input  wire logic sys_clk,
  output      logic sck,
  output      logic cs_n,
  output      logic mosi,
  output      logic hold_n,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       cpol;
  logic [7:0] rx;
  // Select starts low so that reset sees a frame already in progress.
  initial begin
    cpol = 1'b0;
    sck = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    hold_n = 1'b1;
    rx = 8'h00;
  end
  task automatic start;
    @(negedge sys_clk);
    sck = cpol;
    #80;
    cs_n = 1'b0;
    #80;
  endtask
  // A floating return line reads as the inverse of its last bit.
  task automatic bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      mosi = v[i];
      #80;
      sck = 1'b1;
      if (hold_n) rx = {rx[6:0], miso_oe ? miso : ~rx[0]};
      #80;
    end
  endtask
  task automatic stop;
    sck = cpol;
    #80;
    cs_n = 1'b1;
    mosi = ~mosi;
    #160;
  endtask
  task automatic pause(input logic h);
    sck = 1'b0;
    #80;
    hold_n = h;
    #160;
  endtask
endmodule

/* verification/serial_flash_spi_target_test.sv */
// Self-checking bench for the serial flash target and a stalling array.
// Assumes the master model drives the serial pins in 160 ns bit times.
module serial_flash_spi_target_test;
  timeunit 1ns;
  timeprecision 100ps;
  // Opcode values are arbitrary.
  localparam logic [7:0] op_we = 8'h06, op_wd = 8'h04, op_rs = 8'h05;
  localparam logic [7:0] op_ws = 8'h01, op_prog = 8'h02;
  localparam logic [7:0] op_sect = 8'hd8, op_bulk = 8'hc7;
  typedef struct {logic [7:0] op; logic latch;} row_t;
  row_t rows[5] = '{'{op_we, 1'b1}, '{op_rs, 1'b1}, '{op_wd, 1'b0},
                    '{op_we, 1'b1}, '{op_wd, 1'b0}};
  logic        clk, rst, wp_n, boost, rr, done, stall, sck, cs_n, mosi;
  logic        hold_n, miso, oe, stby, busy, wlatch, rv, rfast, rlast;
  logic [2:0]  bp;
  logic [1:0]  rop;
  logic [23:0] raddr;
  logic [7:0]  rdata;
  logic [35:0] q[$];
  int          num_errors, checks, dly;
  spi_master_model m (.sys_clk(clk), .sck(sck), .cs_n(cs_n),
    .mosi(mosi), .hold_n(hold_n), .miso(miso), .miso_oe(oe));
  flash_spi_target #(.OP_WRITE_ENABLE(op_we), .OP_WRITE_DISABLE(op_wd),
    .OP_READ_STATUS(op_rs), .OP_WRITE_STATUS(op_ws),
    .OP_PAGE_PROGRAM(op_prog), .OP_SECTOR_ERASE(op_sect),
    .OP_BULK_ERASE(op_bulk)) uut (
    .SYS_CLK(clk), .SYS_RST(rst), .SPI_CLK(sck), .SPI_CS_N(cs_n),
    .SPI_MOSI(mosi), .HOLD_N(hold_n), .WP_N(wp_n),
    .BOOST_VOLTAGE_LEVEL(boost), .SPI_MISO(miso), .SPI_MISO_OE(oe),
    .STANDBY(stby), .WRITE_IN_PROGRESS_FLAG(busy),
    .WRITE_ENABLE_LATCH(wlatch), .BLOCK_PROTECT(bp),
    .ARRAY_REQ_VALID(rv), .ARRAY_REQ_READY(rr), .ARRAY_REQ_OP(rop),
    .ARRAY_REQ_ADDR(raddr), .ARRAY_REQ_DATA(rdata),
    .ARRAY_REQ_FAST(rfast), .ARRAY_REQ_LAST(rlast), .ARRAY_DONE(done));
  always #2.5 clk = ~clk;
  // Ready alternates unless stalled; done comes late so busy is seen.
  always @(posedge clk) begin
    rr <= ~stall & ~rr;
    done <= (dly == 1);
    if (dly > 0) dly <= dly - 1;
    if (rv && rr) begin
      q.push_back({rop, raddr, rdata, rfast, rlast});
      if (rlast) dly <= 300;
    end
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [31:0] v, input int n);
    m.start();
    m.bits(v, n);
    m.stop();
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic pop(input logic [35:0] exp, input logic [35:0] k = '1);
    chk((q.size() > 0 ? q.pop_front() : ~exp) & k, exp & k);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp_n = 1'b1;
    boost = 1'b0;
    rr = 1'b0;
    done = 1'b0;
    stall = 1'b0;
    dly = 0;
    num_errors = 0;
    checks = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk({busy, wlatch, bp, rv, oe}, 7'h00);
    // Select was low through reset, so this opcode is ignored.
    m.bits(op_we, 8);
    m.stop();
    chk(wlatch, 1'b0);
    foreach (rows[i]) begin
      cmd(rows[i].op, 8);
      chk(wlatch, rows[i].latch);
    end
    chk(stby, 1'b1);
    cmd(op_we, 8);
    m.start();
    m.bits(op_rs, 8);
    m.bits(0, 4);
    m.pause(1'b0);
    chk(oe, 1'b0);
    m.bits(32'hffffffff, 5);
    m.pause(1'b1);
    m.bits(0, 4);
    chk(m.rx, 8'h02);
    m.stop();
    chk(oe, 1'b0);
    m.cpol = 1'b1;
    boost = 1'b1;
    stall = 1'b1;
    cmd(op_we, 8);
    m.start();
    m.bits({op_prog, 24'h0120fe}, 32);
    m.bits(32'h5ac30f, 24);
    m.stop();
    chk({busy, wlatch, stby}, 3'b100);
    stall = 1'b0;
    idle();
    boost = 1'b0;
    pop({2'h0, 24'h0120fe, 8'h5a, 2'b10});
    pop({2'h0, 24'h0120ff, 8'hc3, 2'b10});
    pop({2'h0, 24'h012000, 8'h0f, 2'b11});
    cmd({op_we, 1'b0}, 9);
    chk(wlatch, 1'b0);
    cmd({op_sect, 24'h040000}, 32);
    chk(q.size() + busy, 36'h0);
    cmd(op_we, 8);
    cmd({op_ws, 8'h1c}, 16);
    chk({bp, wlatch}, 4'he);
    cmd(op_we, 8);
    cmd(op_bulk, 8);
    chk(q.size() + busy + wlatch, 36'h0);
    wp_n = 1'b0;
    cmd(op_we, 8);
    cmd({op_ws, 8'h00}, 16);
    chk(bp, 3'h7);
    wp_n = 1'b1;
    cmd(op_we, 8);
    cmd({op_ws, 8'h00}, 16);
    cmd(op_we, 8);
    cmd(op_bulk, 8);
    chk(busy, 1'b1);
    idle();
    pop({2'h2, 24'h0, 8'hff, 2'b01}, {2'h3, 24'h0, 8'hff, 2'h1});
    cmd(op_we, 8);
    cmd({op_sect, 24'h3f0005}, 32);
    idle();
    pop({2'h1, 24'h3c0000, 8'hff, 2'b01},
        {2'h3, 24'hfc0000, 8'hff, 2'h1});
    wrap_up();
  end
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule
